// ---- sitr_pkg.sv ----
/*
  Constants and carrier types for the sampling-instant trim register bank.
  Assumes a plain register port with 12-bit byte offsets and 8-bit data.
*/
package sitr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_TRIM = 6;

  localparam logic [11:0] OFS_CORE_A_DUAL = 12'h310;
  localparam logic [11:0] OFS_CORE_B_DUAL = 12'h313;
  localparam logic [11:0] OFS_CORE_A_SINGLE_FIRST = 12'h314;
  localparam logic [11:0] OFS_CORE_B_SINGLE_FIRST = 12'h315;
  localparam logic [11:0] OFS_CORE_A_SINGLE_SECOND = 12'h31A;
  localparam logic [11:0] OFS_CORE_B_SINGLE_SECOND = 12'h31B;

  // Index order of the trim array
  localparam logic [2:0] IDX_A_DUAL = 3'h0;
  localparam logic [2:0] IDX_B_DUAL = 3'h1;
  localparam logic [2:0] IDX_A_SGL_FIRST = 3'h2;
  localparam logic [2:0] IDX_B_SGL_FIRST = 3'h3;
  localparam logic [2:0] IDX_A_SGL_SECOND = 3'h4;
  localparam logic [2:0] IDX_B_SGL_SECOND = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;

  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sitr_req_s;

  typedef struct packed {
    logic [7:0] core_a;
    logic [7:0] core_b;
  } sitr_trim_s;
endpackage : sitr_pkg

// ---- sitr_regs.sv ----
/*
  Sampling-instant trim register bank: six 8-bit read/write trims and the
  selection of the trims that are live for each converter core.
  Assumes the register master and mode inputs are synchronous to clk, and
  that factory defaults arrive on fuse inputs with a load pulse.
*/
`timescale 1ns/1ns
//
// Contract
// [R1] Eight-bit read/write trim per core and case
// [R2] Factory default loaded; software reads, overwrites
// [R3] Offset 0x310 trims core A, dual mode
// [R4] Offset 0x313 trims core B, dual mode
// [R5] Single mode: core and input pick register (code does so only with fg_cal_en set, else the dual trims drive both cores)
// [R6] Core A single trims use 90-degree phase
// [R7] Inactive trims kept; applied when case active
module sitr_regs import sitr_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire sitr_req_s req,
  output logic [7:0] rdata,
  input wire logic fuse_load,
  input wire logic [47:0] fuse_trim,
  input wire logic single_mode,
  input wire logic fg_cal_en,
  input wire logic second_input_pair,
  output sitr_trim_s trim_out,
  output logic core_a_phase90
);

  logic [7:0] trim_q [NUM_TRIM];

  function automatic logic [2:0] decode(input logic [11:0] a);
    case (a)
      OFS_CORE_A_DUAL: decode = IDX_A_DUAL; // see [R3]
      OFS_CORE_B_DUAL: decode = IDX_B_DUAL; // see [R4]
      OFS_CORE_A_SINGLE_FIRST: decode = IDX_A_SGL_FIRST; // see [R5]
      OFS_CORE_B_SINGLE_FIRST: decode = IDX_B_SGL_FIRST;
      OFS_CORE_A_SINGLE_SECOND: decode = IDX_A_SGL_SECOND;
      OFS_CORE_B_SINGLE_SECOND: decode = IDX_B_SGL_SECOND;
      default: decode = IDX_NONE;
    endcase
  endfunction : decode

  logic [2:0] widx;
  logic [2:0] ridx;
  assign widx = decode(req.addr);
  assign ridx = decode(req.addr);

  // A software write in the same cycle as a fuse load wins: the later
  // intent of software must not be lost to a late factory reload.
  genvar g;
  generate
    for (g = 0; g < NUM_TRIM; g++) begin : g_trim
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          trim_q[g] <= TRIM_RESET;
        end else if (req.wr && widx == 3'(g)) begin
          trim_q[g] <= req.wdata; // see [R1] see [R2]
        end else if (fuse_load) begin
          trim_q[g] <= fuse_trim[g*8 +: 8]; // see [R2]
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= UNMAPPED_READ;
    end else if (req.rd) begin
      if (ridx == IDX_NONE) begin
        rdata <= UNMAPPED_READ;
      end else begin
        rdata <= trim_q[ridx]; // see [R2]
      end
    end else begin
      rdata <= UNMAPPED_READ;
    end
  end

  // Only the selected pair is driven out; the others keep their contents.
  logic [2:0] sel_a;
  logic [2:0] sel_b;
  always_comb begin
    if (single_mode && fg_cal_en) begin
      sel_a = second_input_pair ? IDX_A_SGL_SECOND : IDX_A_SGL_FIRST;
      sel_b = second_input_pair ? IDX_B_SGL_SECOND : IDX_B_SGL_FIRST;
    end else begin
      sel_a = IDX_A_DUAL;
      sel_b = IDX_B_DUAL;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_out <= '0;
      core_a_phase90 <= 1'b0;
    end else begin
      trim_out.core_a <= trim_q[sel_a]; // see [R3] see [R5] see [R7]
      trim_out.core_b <= trim_q[sel_b]; // see [R4] see [R5] see [R7]
      core_a_phase90 <= single_mode && fg_cal_en; // see [R6]
    end
  end

  // Output selection checks. Dual trims also drive the cores in single
  // mode without calibration, so the antecedent is the full case test.
  chk_dual_core_a: assert property (@(posedge clk) // see [R3]
    disable iff (!arst_n)
    !(single_mode && fg_cal_en) |=>
    trim_out.core_a == $past(trim_q[IDX_A_DUAL]))
    else $error("core A dual trim not applied");

  chk_dual_core_b: assert property (@(posedge clk) // see [R4]
    disable iff (!arst_n)
    !(single_mode && fg_cal_en) |=>
    trim_out.core_b == $past(trim_q[IDX_B_DUAL]))
    else $error("core B dual trim not applied");

  chk_single_first_sel: assert property (@(posedge clk) // see [R5]
    disable iff (!arst_n)
    single_mode && fg_cal_en && !second_input_pair |=>
    trim_out.core_a == $past(trim_q[IDX_A_SGL_FIRST]) &&
    trim_out.core_b == $past(trim_q[IDX_B_SGL_FIRST]))
    else $error("first input trims not applied");

  chk_single_second_sel: assert property (@(posedge clk) // see [R5]
    disable iff (!arst_n)
    single_mode && fg_cal_en && second_input_pair |=>
    trim_out.core_a == $past(trim_q[IDX_A_SGL_SECOND]) &&
    trim_out.core_b == $past(trim_q[IDX_B_SGL_SECOND]))
    else $error("second input trims not applied");

  chk_phase_flag: assert property (@(posedge clk) // see [R6]
    disable iff (!arst_n)
    ##1 core_a_phase90 == $past(single_mode && fg_cal_en))
    else $error("phase flag wrong");

  chk_phase_high: assert property (@(posedge clk) // see [R6]
    disable iff (!arst_n)
    single_mode && fg_cal_en |=> core_a_phase90)
    else $error("phase flag low in calibrated single mode");

  chk_phase_low: assert property (@(posedge clk) // see [R6]
    disable iff (!arst_n)
    !(single_mode && fg_cal_en) |=> !core_a_phase90)
    else $error("phase flag high outside its case");

  // Register port checks. A read returns what the previous cycle wrote,
  // since the write lands one edge before the edge that samples the read strobe.
  chk_write_readback: assert property (@(posedge clk) // see [R1]
    disable iff (!arst_n)
    req.wr && decode(req.addr) != IDX_NONE ##1
    req.rd && req.addr == $past(req.addr) |=>
    rdata == $past(req.wdata, 2))
    else $error("write not read back");

  chk_fuse_load: assert property (@(posedge clk) // see [R2]
    disable iff (!arst_n)
    fuse_load && !req.wr |=> trim_q[IDX_A_DUAL] == $past(fuse_trim[7:0]))
    else $error("factory trim not loaded");

  chk_inactive_kept: assert property (@(posedge clk) // see [R7]
    disable iff (!arst_n)
    !req.wr && !fuse_load |=> $stable(trim_q[IDX_B_SGL_SECOND]))
    else $error("inactive trim changed");

  chk_unmapped_read: assert property (@(posedge clk) // see [R2]
    disable iff (!arst_n)
    req.rd && decode(req.addr) == IDX_NONE |=> rdata == UNMAPPED_READ)
    else $error("unmapped read not zero");

  // Read data must not linger: software may poll with no gap between
  // strobes, and a stale byte would look like a fresh answer.
  chk_read_one_cycle: assert property (@(posedge clk) // see [R2]
    disable iff (!arst_n)
    !req.rd |=> rdata == UNMAPPED_READ)
    else $error("read data stood too long");

  // An unmapped write must not alias onto either dual-mode trim.
  chk_unmapped_write: assert property (@(posedge clk) // see [R1]
    disable iff (!arst_n)
    req.wr && decode(req.addr) == IDX_NONE && !fuse_load |=>
    $stable(trim_q[IDX_A_DUAL]) && $stable(trim_q[IDX_B_DUAL]))
    else $error("unmapped write changed a trim");

  // Per-trim checks. A trim that holds its value while its case is
  // inactive is what lets software park values ahead of a mode change.
  generate
    for (g = 0; g < NUM_TRIM; g++) begin : g_chk
      chk_write_lands: assert property (@(posedge clk) // see [R1]
        disable iff (!arst_n)
        req.wr && decode(req.addr) == 3'(g) |=>
        trim_q[g] == $past(req.wdata))
        else $error("trim write not stored");

      chk_fuse_fills: assert property (@(posedge clk) // see [R2]
        disable iff (!arst_n)
        fuse_load && !(req.wr && decode(req.addr) == 3'(g)) |=>
        trim_q[g] == $past(fuse_trim[g*8 +: 8]))
        else $error("factory trim not stored");

      chk_trim_held: assert property (@(posedge clk) // see [R7]
        disable iff (!arst_n)
        !fuse_load && !(req.wr && decode(req.addr) == 3'(g)) |=>
        $stable(trim_q[g]))
        else $error("trim changed without a write");

      chk_read_returns: assert property (@(posedge clk) // see [R2]
        disable iff (!arst_n)
        req.rd && decode(req.addr) == 3'(g) |=>
        rdata == $past(trim_q[g]))
        else $error("read did not return the trim");
    end
  endgenerate
endmodule : sitr_regs

// ---- sitr_tb.sv ----
/*
  Self-checking testbench for the sampling-instant trim register bank.
  Assumes sitr_pkg and sitr_regs are compiled first.
  Assertions live inside the design files.
*/
`timescale 1ns/1ns
module testbench import sitr_pkg::*;;
  logic clk, arst_n, fuse_load, single_mode, fg_cal_en, second_input_pair;
  logic [47:0] fuse_trim;
  logic [7:0] rdata;
  logic core_a_phase90;
  sitr_req_s req;
  sitr_trim_s trim_out;
  int failures = 0;
  int n_compared = 0;
  logic [11:0] ofs [6] = '{OFS_CORE_A_DUAL, OFS_CORE_B_DUAL,
    OFS_CORE_A_SINGLE_FIRST, OFS_CORE_B_SINGLE_FIRST,
    OFS_CORE_A_SINGLE_SECOND, OFS_CORE_B_SINGLE_SECOND};

  sitr_regs u_dut (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
    .fuse_load(fuse_load), .fuse_trim(fuse_trim),
    .single_mode(single_mode), .fg_cal_en(fg_cal_en),
    .second_input_pair(second_input_pair), .trim_out(trim_out),
    .core_a_phase90(core_a_phase90));

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk("rdata", e, rdata);
    @(posedge clk);
    #1 chk("rdata_idle", UNMAPPED_READ, rdata);
  endtask : rd

  // Write then read with no gap between the strobes
  task wr_rd(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk("rdata_b2b", d, rdata);
  endtask : wr_rd

  task mode(input logic s, f, b, input logic [7:0] ea, eb, input logic p);
    @(posedge clk);
    single_mode <= s;
    fg_cal_en <= f;
    second_input_pair <= b;
    repeat (2) @(posedge clk);
    #1 chk("core_a", ea, trim_out.core_a);
    chk("core_b", eb, trim_out.core_b);
    chk("phase90", {7'h00, p}, {7'h00, core_a_phase90});
  endtask : mode

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial begin
    arst_n = 1'b0;
    req = '0;
    fuse_load = 1'b0;
    fuse_trim = 48'h665544332211;
    {single_mode, fg_cal_en, second_input_pair} = 3'h0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 6; k++) rd(ofs[k], TRIM_RESET);
    @(posedge clk);
    fuse_load <= 1'b1;
    @(posedge clk);
    fuse_load <= 1'b0;
    for (int k = 0; k < 6; k++) rd(ofs[k], fuse_trim[k*8 +: 8]);
    for (int k = 0; k < 6; k++) wr(ofs[k], 8'(8'hA0 + k));
    wr(12'h311, 8'hFF);
    rd(12'h311, UNMAPPED_READ);
    for (int k = 0; k < 6; k++) rd(ofs[k], 8'(8'hA0 + k));
    mode(1'b0, 1'b0, 1'b0, 8'hA0, 8'hA1, 1'b0);
    mode(1'b1, 1'b0, 1'b1, 8'hA0, 8'hA1, 1'b0);
    mode(1'b1, 1'b1, 1'b0, 8'hA2, 8'hA3, 1'b1);
    mode(1'b1, 1'b1, 1'b1, 8'hA4, 8'hA5, 1'b1);
    mode(1'b0, 1'b1, 1'b1, 8'hA0, 8'hA1, 1'b0);
    wr_rd(OFS_CORE_B_DUAL, 8'h5A);
    mode(1'b0, 1'b0, 1'b0, 8'hA0, 8'h5A, 1'b0);
    print_verdict();
  end
endmodule : testbench
